/* File: include/sppo_defs.svh */
// Register offsets, reset values, field positions and timing constants of the servo output block.
`ifndef SPPO_DEFS_SVH
`define SPPO_DEFS_SVH
`define SPPO_OFS_TUNE_MODE 8'h00
`define SPPO_OFS_TUNE_RESP 8'h04
`define SPPO_OFS_POS_WIN 8'h08
`define SPPO_OFS_ROT_SENSE 8'h0C
`define SPPO_OFS_ENC_OUT 8'h10
`define SPPO_OFS_PULSE_MODE 8'h14
`define SPPO_OFS_CTRL 8'h18
`define SPPO_OFS_STATUS 8'h1C
`define SPPO_OFS_RES_FREQ 8'h20
`define SPPO_RST_TUNE_MODE 16'h0001
`define SPPO_RST_TUNE_RESP 16'h000C
`define SPPO_RST_POS_WIN 16'h0064
`define SPPO_RST_ROT_SENSE 16'h0000
`define SPPO_RST_ENC_OUT 16'h0FA0
`define SPPO_RST_PULSE_MODE 16'h0000
`define SPPO_RESP_MIN 16'h0001
`define SPPO_RESP_MAX 16'h0020
`define SPPO_PMODE_BIT 4
`define SPPO_CTRL_RESET_BIT 0
`define SPPO_CTRL_SPEED_BIT 1
`define SPPO_MAX_OUT_RATE_HZ 4600000
`define SPPO_CLK_HZ 250000000
`define SPPO_MIN_EDGE_CYC ((`SPPO_CLK_HZ + `SPPO_MAX_OUT_RATE_HZ - 1) / `SPPO_MAX_OUT_RATE_HZ)
`endif

/* File: include/sppo_pkg.sv */
// Types shared by the servo output block.
package sppo_pkg;
    typedef logic [15:0] sppo_param_t;
    typedef enum logic [1:0] {
        SPPO_AXI_IDLE,
        SPPO_AXI_RESP
    } sppo_bus_e;
endpackage : sppo_pkg

/* File: logic/sppo_res_lut.sv */
// Lookup of the guideline machine resonance frequency for each response setting.
`timescale 1ns/1ps
module sppo_res_lut (
    input wire logic [5:0] level_i,
    output logic [15:0] freq_x10_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Table in tenths of hertz; settings outside 1..32 read as zero.
    always_comb begin
        unique case (level_i)
            6'd1: freq_x10_o = 16'd100;
            6'd2: freq_x10_o = 16'd113;
            6'd3: freq_x10_o = 16'd127;
            6'd4: freq_x10_o = 16'd143;
            6'd5: freq_x10_o = 16'd161;
            6'd6: freq_x10_o = 16'd181;
            6'd7: freq_x10_o = 16'd204;
            6'd8: freq_x10_o = 16'd230;
            6'd9: freq_x10_o = 16'd259;
            6'd10: freq_x10_o = 16'd292;
            6'd11: freq_x10_o = 16'd329;
            6'd12: freq_x10_o = 16'd370;
            6'd13: freq_x10_o = 16'd417;
            6'd14: freq_x10_o = 16'd470;
            6'd15: freq_x10_o = 16'd529;
            6'd16: freq_x10_o = 16'd596;
            6'd17: freq_x10_o = 16'd671;
            6'd18: freq_x10_o = 16'd756;
            6'd19: freq_x10_o = 16'd852;
            6'd20: freq_x10_o = 16'd959;
            6'd21: freq_x10_o = 16'd1080;
            6'd22: freq_x10_o = 16'd1217;
            6'd23: freq_x10_o = 16'd1371;
            6'd24: freq_x10_o = 16'd1544;
            6'd25: freq_x10_o = 16'd1739;
            6'd26: freq_x10_o = 16'd1959;
            6'd27: freq_x10_o = 16'd2206;
            6'd28: freq_x10_o = 16'd2485;
            6'd29: freq_x10_o = 16'd2799;
            6'd30: freq_x10_o = 16'd3153;
            6'd31: freq_x10_o = 16'd3551;
            6'd32: freq_x10_o = 16'd4000;
            default: freq_x10_o = 16'd0;
        endcase
    end
endmodule : sppo_res_lut

/* File: logic/sppo_quad_gen.sv */
// Quadrature generator: divides encoder counts into A/B output edges.
`timescale 1ns/1ps
`include "sppo_defs.svh"
module sppo_quad_gen #(
    parameter int RES_W = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic [RES_W-1:0] resolution_i,
    input wire logic [15:0] setting_i,
    input wire logic ratio_mode_i,
    output logic pha_o,
    output logic phb_o
);
    localparam logic [7:0] MIN_GAP = 8'(`SPPO_MIN_EDGE_CYC);
    // Accumulator for the fractional division of encoder counts.
    logic [RES_W+16:0] acc_q, acc_d;
    // Two-bit gray state; each state step is one output edge.
    logic [1:0] st_q, st_d;
    // Pending edges owed, signed by direction.
    logic signed [15:0] owe_q, owe_d;
    // Edge spacing counter that keeps the output under the rate limit.
    logic [7:0] gap_q, gap_d;
    logic [RES_W+16:0] inc;
    logic [RES_W+16:0] modulus;
    ////////////////////////////////////////////////////////////////////////////
    // In direct mode each encoder count adds the output count per revolution; one output edge
    // is owed whenever the sum passes the encoder resolution; ratio mode adds one per count against the setting.
    always_comb begin
        inc = (RES_W+17)'(setting_i);
        modulus = (RES_W+17)'(resolution_i);
        if (ratio_mode_i) begin
            inc = (RES_W+17)'(1);
            modulus = (RES_W+17)'(setting_i);
        end
        acc_d = acc_q;
        owe_d = owe_q;
        st_d = st_q;
        gap_d = (gap_q != 8'h00) ? gap_q - 8'h01 : gap_q;
        if (step_i) begin
            if (acc_q + inc >= modulus) begin
                acc_d = acc_q + inc - modulus;
                owe_d = dir_i ? owe_q + 16'sd1 : owe_q - 16'sd1;
            end else begin
                acc_d = acc_q + inc;
            end
        end
        if (gap_q == 8'h00 && owe_q != 16'sd0) begin
            gap_d = MIN_GAP - 8'h01;
            if (owe_q > 16'sd0) begin
                // Forward steps move A first, so A leads B.
                st_d = {~st_q[0], st_q[1]};
                owe_d = owe_d - 16'sd1;
            end else begin
                st_d = {st_q[0], ~st_q[1]};
                owe_d = owe_d + 16'sd1;
            end
        end
    end
    // State registers only.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
            owe_q <= 16'sd0;
            st_q <= 2'b00;
            gap_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
            owe_q <= owe_d;
            st_q <= st_d;
            gap_q <= gap_d;
        end
    end
    assign pha_o = st_q[1];
    assign phb_o = st_q[0];
    ////////////////////////////////////////////////////////////////////////////
    // Only one phase changes per edge.
    quad_gray_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $countones(st_q ^ $past(st_q)) <= 1) else $error("both phases changed");
    rate_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (st_q != $past(st_q)) |=> (st_q == $past(st_q))) else $error("edges too close");
endmodule : sppo_quad_gen

/* File: logic/sppo_top.sv */
// Servo position and output parameter block with AXI4-Lite register access.
`timescale 1ns/1ps
`include "sppo_defs.svh"
module sppo_top
    import sppo_pkg::*;
#(
    parameter int RES_W = 20,
    parameter logic [RES_W-1:0] ENC_RES = 20'd262144
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [31:0] pos_error_i,
    input wire logic enc_step_i,
    input wire logic enc_dir_i,
    output logic position_reached_o,
    output logic motor_dir_o,
    output logic enc_pha_o,
    output logic enc_phb_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass two flip-flops; stage one feeds stage two only.
    // Step edges are found on the second stage, clear of metastability.
    logic [2:1] pin_s1_q, pin_s2_q;
    logic step_prev_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 2'b00;
            pin_s2_q <= 2'b00;
            step_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= {enc_dir_i, enc_step_i};
            pin_s2_q <= pin_s1_q;
            step_prev_q <= pin_s2_q[1];
        end
    end
    wire logic step_pulse = pin_s2_q[1] & ~step_prev_q;
    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers as written by software.
    sppo_param_t tune_mode_q, tune_mode_d;
    sppo_param_t tune_resp_q, tune_resp_d;
    sppo_param_t pos_win_q, pos_win_d;
    sppo_param_t rot_sense_q, rot_sense_d;
    sppo_param_t enc_out_q, enc_out_d;
    sppo_param_t pulse_mode_q, pulse_mode_d;
    // Control bits: controller reset request and speed control mode.
    logic speed_mode_q, speed_mode_d;
    // Applied copies that only change at reset or controller reset.
    logic rot_sense_act_q, rot_sense_act_d;
    sppo_param_t enc_out_act_q, enc_out_act_d;
    logic ratio_act_q, ratio_act_d;
    // Bus handshake state.
    sppo_bus_e wr_st_q, wr_st_d, rd_st_q, rd_st_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    // Lookup output, in-position flag and the one-cycle controller reset strobe.
    logic [15:0] res_freq;
    logic in_pos_q, in_pos_d, ctrl_reset;
    // Byte-lane merge for the 16-bit registers.
    function automatic sppo_param_t merge16(sppo_param_t old, logic [31:0] d, logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction : merge16
    // Mapped offset test shared by both channels.
    function automatic logic is_mapped(logic [7:0] a);
        is_mapped = (a <= `SPPO_OFS_RES_FREQ) && (a[1:0] == 2'b00);
    endfunction : is_mapped
    sppo_res_lut u_lut (.level_i(tune_resp_q[5:0]), .freq_x10_o(res_freq));
    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, then response.
    always_comb begin
        wr_st_d = wr_st_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bresp_d = bresp_q;
        tune_mode_d = tune_mode_q;
        tune_resp_d = tune_resp_q;
        pos_win_d = pos_win_q;
        rot_sense_d = rot_sense_q;
        enc_out_d = enc_out_q;
        pulse_mode_d = pulse_mode_q;
        speed_mode_d = speed_mode_q;
        ctrl_reset = 1'b0;
        unique case (wr_st_q)
            SPPO_AXI_IDLE: begin
                if (s_axi_awvalid && !aw_got_q) begin
                    aw_got_d = 1'b1;
                    aw_addr_d = s_axi_awaddr[7:0];
                end
                if (s_axi_wvalid && !w_got_q) begin
                    w_got_d = 1'b1;
                    w_data_d = s_axi_wdata;
                    w_strb_d = s_axi_wstrb;
                end
                if (aw_got_q && w_got_q) begin
                    wr_st_d = SPPO_AXI_RESP;
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    bresp_d = is_mapped(aw_addr_q) ? 2'b00 : 2'b10;
                    unique case (aw_addr_q)
                        `SPPO_OFS_TUNE_MODE: tune_mode_d = merge16(tune_mode_q, w_data_q, w_strb_q);
                        `SPPO_OFS_TUNE_RESP: begin
                            if (w_strb_q[0] && w_data_q[15:0] >= `SPPO_RESP_MIN
                                && w_data_q[15:0] <= `SPPO_RESP_MAX) begin
                                tune_resp_d = w_data_q[15:0];
                            end
                        end
                        `SPPO_OFS_POS_WIN: pos_win_d = merge16(pos_win_q, w_data_q, w_strb_q);
                        `SPPO_OFS_ROT_SENSE: begin
                            if (w_strb_q[0]) rot_sense_d = {15'h0000, w_data_q[0]};
                        end
                        `SPPO_OFS_ENC_OUT: begin
                            if (merge16(enc_out_q, w_data_q, w_strb_q) != 16'h0000) begin
                                enc_out_d = merge16(enc_out_q, w_data_q, w_strb_q);
                            end
                        end
                        `SPPO_OFS_PULSE_MODE: pulse_mode_d = merge16(pulse_mode_q, w_data_q, w_strb_q);
                        `SPPO_OFS_CTRL: begin
                            if (w_strb_q[0]) begin
                                ctrl_reset = w_data_q[`SPPO_CTRL_RESET_BIT];
                                speed_mode_d = w_data_q[`SPPO_CTRL_SPEED_BIT];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SPPO_AXI_RESP: if (s_axi_bready) wr_st_d = SPPO_AXI_IDLE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Applied settings; writes to rotation sense, encoder output or pulse mode take effect only on a controller reset.
    always_comb begin
        rot_sense_act_d = rot_sense_act_q;
        enc_out_act_d = enc_out_act_q;
        ratio_act_d = ratio_act_q;
        if (ctrl_reset) begin
            rot_sense_act_d = rot_sense_q[0];
            enc_out_act_d = enc_out_q;
            ratio_act_d = pulse_mode_q[`SPPO_PMODE_BIT];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, answer the cycle after the address.
    always_comb begin
        rd_st_d = rd_st_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        unique case (rd_st_q)
            SPPO_AXI_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_st_d = SPPO_AXI_RESP;
                    rresp_d = is_mapped(s_axi_araddr[7:0]) ? 2'b00 : 2'b10;
                    unique case (s_axi_araddr[7:0])
                        `SPPO_OFS_TUNE_MODE: rdata_d = {16'h0000, tune_mode_q};
                        `SPPO_OFS_TUNE_RESP: rdata_d = {16'h0000, tune_resp_q};
                        `SPPO_OFS_POS_WIN: rdata_d = {16'h0000, pos_win_q};
                        `SPPO_OFS_ROT_SENSE: rdata_d = {16'h0000, rot_sense_q};
                        `SPPO_OFS_ENC_OUT: rdata_d = {16'h0000, enc_out_q};
                        `SPPO_OFS_PULSE_MODE: rdata_d = {16'h0000, pulse_mode_q};
                        `SPPO_OFS_CTRL: rdata_d = {30'h00000000, speed_mode_q, 1'b0};
                        `SPPO_OFS_STATUS: rdata_d = {29'h00000000, ratio_act_q,
                            rot_sense_act_q, in_pos_q};
                        `SPPO_OFS_RES_FREQ: rdata_d = {16'h0000, res_freq};
                        default: rdata_d = 32'h00000000;
                    endcase
                end
            end
            SPPO_AXI_RESP: if (s_axi_rready) rd_st_d = SPPO_AXI_IDLE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // In-position detection against the window on the absolute error.
    always_comb begin
        in_pos_d = 1'b0;
        if (!speed_mode_q) begin
            in_pos_d = (pos_error_i < 0 ? 33'(-33'(pos_error_i)) : 33'(pos_error_i))
                <= 33'(pos_win_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Register stage for the bus, parameter, applied and in-position state groups.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_st_q <= SPPO_AXI_IDLE;
            rd_st_q <= SPPO_AXI_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bresp_q <= 2'b00;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
            tune_mode_q <= `SPPO_RST_TUNE_MODE;
            tune_resp_q <= `SPPO_RST_TUNE_RESP;
            pos_win_q <= `SPPO_RST_POS_WIN;
            rot_sense_q <= `SPPO_RST_ROT_SENSE;
            enc_out_q <= `SPPO_RST_ENC_OUT;
            pulse_mode_q <= `SPPO_RST_PULSE_MODE;
            speed_mode_q <= 1'b0;
            rot_sense_act_q <= 1'b0;
            enc_out_act_q <= `SPPO_RST_ENC_OUT;
            ratio_act_q <= 1'b0;
            in_pos_q <= 1'b0;
        end else begin
            wr_st_q <= wr_st_d;
            rd_st_q <= rd_st_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bresp_q <= bresp_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            tune_mode_q <= tune_mode_d;
            tune_resp_q <= tune_resp_d;
            pos_win_q <= pos_win_d;
            rot_sense_q <= rot_sense_d;
            enc_out_q <= enc_out_d;
            pulse_mode_q <= pulse_mode_d;
            speed_mode_q <= speed_mode_d;
            rot_sense_act_q <= rot_sense_act_d;
            enc_out_act_q <= enc_out_act_d;
            ratio_act_q <= ratio_act_d;
            in_pos_q <= in_pos_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Motor direction, quadrature and handshake outputs, all registered.
    logic qa, qb, dir_q, pha_q, phb_q;
    sppo_quad_gen #(.RES_W(RES_W)) u_quad (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .step_i(step_pulse), .dir_i(pin_s2_q[2]), .resolution_i(ENC_RES),
        .setting_i(enc_out_act_q), .ratio_mode_i(ratio_act_q), .pha_o(qa), .phb_o(qb));
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q <= 1'b0;
            pha_q <= 1'b0;
            phb_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end else begin
            dir_q <= pin_s2_q[2] ^ rot_sense_act_q;
            pha_q <= qa;
            phb_q <= qb;
            // Ready and valid follow the next bus state, so no gate sits on the pins.
            s_axi_awready <= (wr_st_d == SPPO_AXI_IDLE) && !aw_got_d;
            s_axi_wready <= (wr_st_d == SPPO_AXI_IDLE) && !w_got_d;
            s_axi_bvalid <= (wr_st_d == SPPO_AXI_RESP);
            s_axi_arready <= (rd_st_d == SPPO_AXI_IDLE);
            s_axi_rvalid <= (rd_st_d == SPPO_AXI_RESP);
        end
    end
    assign s_axi_bresp = bresp_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign position_reached_o = in_pos_q;
    assign motor_dir_o = dir_q;
    assign enc_pha_o = pha_q;
    assign enc_phb_o = phb_q;
    ////////////////////////////////////////////////////////////////////////////
    resp_range_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tune_resp_q >= `SPPO_RESP_MIN && tune_resp_q <= `SPPO_RESP_MAX) else $error("resp out");
    speed_nowin_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        speed_mode_q |=> !position_reached_o) else $error("window active in speed mode");
    dir_sense_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        1'b1 |=> motor_dir_o == ($past(pin_s2_q[2]) ^ $past(rot_sense_act_q))) else $error("dir");
    apply_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ctrl_reset |=> $stable(enc_out_act_q) && $stable(rot_sense_act_q)) else $error("early");
    enc_nonzero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        enc_out_q != 16'h0000) else $error("encoder out setting zero");
    win_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!speed_mode_q && pos_error_i == 32'sd0) |=> position_reached_o) else $error("inpos");
    rmode_apply_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ctrl_reset |=> ratio_act_q == $past(pulse_mode_q[`SPPO_PMODE_BIT])) else $error("mode");
    bresp_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("bvalid dropped");
    wr_done_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_axi_bvalid && s_axi_bready);
    rd_done_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_axi_rvalid && s_axi_rready);
    inpos_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) position_reached_o);
    apply_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ctrl_reset);
endmodule : sppo_top

/* File: verif/sppo_enc_model.sv */
// Encoder model: a burst of evenly spaced count strobes with a direction level.
`timescale 1ns/1ps
module sppo_enc_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic fwd_i,
    output logic step_o,
    output logic dir_o
);
    logic [6:0] cnt_q;
    // slow strobes
    // A strobe every 128 cycles keeps the divided output far below the rate ceiling.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 7'h00;
        else cnt_q <= run_i ? cnt_q + 7'h01 : 7'h00;
    end
    assign step_o = run_i & cnt_q[6];
    assign dir_o = fwd_i;
endmodule : sppo_enc_model

/* File: verif/tb.sv */
// Self-checking bench for the servo output block.
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 0, rst_n_i = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, run = 0, fwd = 1;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd, got;
    logic signed [31:0] pe = 0;
    logic [1:0] br, rr, resp;
    logic aw_r, w_r, bv, ar_r, rv, reached, mdir, pha, phb, step, edir, pa = 0, pb = 0;
    integer seed = 22109;
    int n_errors = 0, comparisons = 0, ntr = 0, nfwd = 0, e, x;
    int rst_v [5] = '{1, 12, 100, 0, 4000};
    sppo_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .pos_error_i(pe), .enc_step_i(step), .enc_dir_i(edir), .position_reached_o(reached),
        .motor_dir_o(mdir), .enc_pha_o(pha), .enc_phb_o(phb));
    sppo_enc_model enc (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .run_i(run), .fwd_i(fwd),
        .step_o(step), .dir_o(edir));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    initial begin
        #160000;
        n_errors++;
        results();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // Ready is sampled at the falling edge, where it already holds its value for the next rise.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr;
        @(posedge clk_sys_i);
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            ta = awv & aw_r;
            tw = wv & w_r;
            tr = bv;
            resp = br;
            @(posedge clk_sys_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tr);
        bre <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk_sys_i);
        ara <= {24'h0, a};
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            ta = arv & ar_r;
            tr = rv;
            got = rd;
            resp = rr;
            @(posedge clk_sys_i);
            if (ta) arv <= 1'b0;
        end while (!tr);
        rre <= 1'b0;
    endtask : rdr
    task automatic results();
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // Phase monitor: forward steps leave B equal to the previous A.
    always @(negedge clk_sys_i) begin
        if (pha !== pa || phb !== pb) begin
            ntr++;
            if (phb === pa) nfwd++;
            pa = pha;
            pb = phb;
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rdr(8'(i * 4));
            chk(got, rst_v[i]);
        end
        rdr(8'h40);
        chk({30'h0, resp}, 32'h2); // unmapped
        wr(8'h40, 0);
        chk({30'h0, resp}, 32'h2); // unmapped
        wr(8'h04, 33);
        chk({30'h0, resp}, 32'h0);
        rdr(8'h04);
        chk(got, 12);
        for (int lv = 1; lv <= 32; lv += 31) begin
            wr(8'h04, lv);
            rdr(8'h20);
            chk(got, lv == 1 ? 100 : 4000);
        end
        for (int i = 0; i < 24; i++) begin
            e = i == 0 ? 100 : i == 1 ? -101 : i == 23 ? 0 : $random(seed) % 200;
            @(posedge clk_sys_i);
            pe <= e;
            repeat (2) @(negedge clk_sys_i);
            chk(reached, e <= 100 && e >= -100);
        end
        wr(8'h18, 2);
        repeat (3) @(negedge clk_sys_i);
        chk(reached, 0);
        wr(8'h18, 0);
        wr(8'h10, 4);
        wr(8'h10, 0);
        rdr(8'h10);
        chk(got, 4);
        wr(8'h14, 32'h10);
        rdr(8'h1C);
        chk(got[2], 0);
        wr(8'h18, 1);
        rdr(8'h1C);
        chk(got[2], 1);
        // Forty counts per pass: a ratio of four gives ten steps each way, then
        // direct count mode gives forty times the setting over the resolution.
        for (int p = 0; p < 3; p++) begin
            if (p == 2) begin
                wr(8'h10, 65535);
                wr(8'h14, 0);
                wr(8'h18, 1);
            end
            @(posedge clk_sys_i);
            fwd <= (p != 1);
            ntr = 0;
            nfwd = 0;
            run <= 1'b1;
            repeat (5120) @(posedge clk_sys_i);
            run <= 1'b0;
            repeat (1000) @(posedge clk_sys_i);
            x = p < 2 ? 40 / 4 : 40 * 65535 / 262144;
            chk(ntr, x);
            chk(nfwd, p == 1 ? 0 : x);
        end
        wr(8'h0C, 1);
        repeat (4) @(negedge clk_sys_i);
        chk(mdir, fwd);
        wr(8'h18, 1);
        repeat (4) @(negedge clk_sys_i);
        chk(mdir, !fwd);
        results();
    end
endmodule : tb
